/* hw/alarm_control_status_regs.sv */
// Control and status register pair with alarm output routing
`include "alarm_regs_cfg.svh"
module alarm_control_status_regs (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  reg_wr,
  input  wire alarm_regs_pkg::reg_addr_t reg_addr,
  input  wire alarm_regs_pkg::reg_byte_t reg_wdata,
  output      alarm_regs_pkg::reg_byte_t reg_rdata,
  input  wire logic                  vcc_good,
  input  wire logic                  bat_good,
  input  wire logic                  reset_output_sense_n,
  input  wire logic                  wd_timeout,
  input  wire logic                  alarm_equal,
  input  wire logic                  hour_mark,
  input  wire logic                  bat_below_trip,
  input  wire logic                  watchdog_kick_input,
  input  wire logic                  write_protect_input_n,
  output      logic                  alarm_output_n,
  output      logic                  watchdog_output_n,
  output      logic                  watchdog_restart,
  output      logic                  battery_test_start,
  output      alarm_regs_pkg::trip_sel_t battery_trip_select,
  output      logic                  oscillator_run
);
  import alarm_regs_pkg::*;

  event_sync_if ev ();

  event_sync u_sync (
    .sys_clk               (sys_clk),
    .rst                   (rst),
    .vcc_good              (vcc_good),
    .bat_good              (bat_good),
    .reset_output_sense_n  (reset_output_sense_n),
    .wd_timeout            (wd_timeout),
    .alarm_equal           (alarm_equal),
    .hour_mark             (hour_mark),
    .bat_below_trip        (bat_below_trip),
    .watchdog_kick_input   (watchdog_kick_input),
    .write_protect_input_n (write_protect_input_n),
    .ev                    (ev)
  );

  reg_byte_t multifunction_control;
  reg_byte_t alarm_status_flags;
  reg_byte_t next_control;
  reg_byte_t next_status;
  logic      test_pending;

  wire ctrl_sel = reg_wr && (reg_addr == `ADDR_CONTROL);
  wire stat_sel = reg_wr && (reg_addr == `ADDR_STATUS);

  wire clock_alarm_enable     = multifunction_control[`CB_CLK_ALARM_EN];
  wire osc_on                 = multifunction_control[`CB_OSC_RUN];
  wire watchdog_enable        = multifunction_control[`CB_WD_EN];
  wire watchdog_pin_select    = multifunction_control[`CB_WD_PIN_SEL];
  wire battery_monitor_enable = multifunction_control[`CB_BAT_MON_EN];

  // Only bits 6:0 are storable, so bit 7 stays zero
  wire [7:0] ctrl_written = reg_wdata & `CTRL_WMASK;
  assign next_control = ev.bat_attach ? `CTRL_RESET
                      : ctrl_sel ? ctrl_written : multifunction_control;

  wire bme_rise = ctrl_sel && ctrl_written[`CB_BAT_MON_EN]
                  && !battery_monitor_enable;
  wire wde_rise = ctrl_sel && ctrl_written[`CB_WD_EN] && !watchdog_enable;

  // Requests wait for the oscillator; tests are not run while halted
  wire test_req = battery_monitor_enable
                  && (ev.hour_tick || ev.vcc_up);
  wire test_go  = (test_req || bme_rise || test_pending) && osc_on
                  && (battery_monitor_enable || bme_rise);

  wire set_rst  = ev.reset_pulse || ev.vcc_up;
  wire set_wda  = watchdog_enable && ev.wd_expire;
  wire set_clock_alarm_flag = clock_alarm_enable && osc_on
                  && ev.alarm_match;
  wire set_bor  = ev.bat_attach;
  wire set_por  = ev.vcc_up;
  wire set_low_battery_flag = battery_monitor_enable && ev.bat_low
                  && battery_test_start;

  // Sets win over a simultaneous status write so no event is lost
  always_comb begin
    next_status = stat_sel ? `STAT_RESET : alarm_status_flags;
    next_status[`REG_TOP_BIT] = 1'b0;
    if (ev.bat_attach) begin
      next_status[`SB_RESET_PULSE] = 1'b0;
      next_status[`SB_WD_ALARM]    = 1'b0;
      next_status[`SB_CLK_ALARM]   = 1'b0;
      next_status[`SB_POWER_ON]    = 1'b0;
      next_status[`SB_LOW_BAT]     = 1'b0;
    end
    if (ev.vcc_up) begin
      next_status[`SB_WD_ALARM]  = 1'b0;
      next_status[`SB_CLK_ALARM] = 1'b0;
    end
    if (set_rst)  next_status[`SB_RESET_PULSE] = 1'b1;
    if (set_wda)  next_status[`SB_WD_ALARM]    = 1'b1;
    if (set_clock_alarm_flag) next_status[`SB_CLK_ALARM]   = 1'b1;
    if (set_bor)  next_status[`SB_BAT_ATTACH]  = 1'b1;
    if (set_por)  next_status[`SB_POWER_ON]    = 1'b1;
    if (set_low_battery_flag) next_status[`SB_LOW_BAT]     = 1'b1;
    // Live pin level, reloaded every cycle; a status write never clears it
    next_status[`SB_WP_LEVEL] = ev.wp_level;
  end

  wire bat_flag = alarm_status_flags[`SB_LOW_BAT];
  wire clk_flag = alarm_status_flags[`SB_CLK_ALARM];
  wire wd_flag  = alarm_status_flags[`SB_WD_ALARM];
  wire next_alarm_n = ~(next_status[`SB_LOW_BAT]
                      | next_status[`SB_CLK_ALARM]
                      | (next_status[`SB_WD_ALARM]
                         & next_control[`CB_WD_PIN_SEL]));
  wire next_wd_n = ~(next_status[`SB_WD_ALARM]
                     & ~next_control[`CB_WD_PIN_SEL]);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      multifunction_control <= `CTRL_RESET;
      alarm_status_flags    <= `STAT_RESET;
      test_pending          <= 1'b0;
    end else begin
      multifunction_control <= next_control;
      alarm_status_flags    <= next_status;
      test_pending <= (test_pending || test_req || bme_rise) && !test_go
                      && !ev.bat_attach;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alarm_output_n      <= 1'b1;
      watchdog_output_n   <= 1'b1;
      watchdog_restart    <= 1'b0;
      battery_test_start  <= 1'b0;
      battery_trip_select <= 2'h0;
      oscillator_run      <= 1'b0;
      reg_rdata           <= 8'h00;
    end else begin
      alarm_output_n      <= next_alarm_n;
      watchdog_output_n   <= next_wd_n;
      watchdog_restart    <= wde_rise || ev.vcc_up || ev.kick;
      battery_test_start  <= test_go;
      battery_trip_select <= next_control[`CB_TRIP_HI:`CB_TRIP_LO];
      oscillator_run      <= next_control[`CB_OSC_RUN];
      reg_rdata <= (reg_addr == `ADDR_CONTROL) ? multifunction_control
                 : (reg_addr == `ADDR_STATUS) ? alarm_status_flags : 8'h00;
    end
  end

  // A status write only clears what no event sets in the same cycle

  AST_CTRL_TOP_ZERO: assert property (
    @(posedge sys_clk) disable iff (rst)
    multifunction_control[`REG_TOP_BIT] == 1'b0)
    else $error("control bit 7 set");

  AST_CTRL_WRITE_LANDS: assert property (
    @(posedge sys_clk) disable iff (rst)
    ctrl_sel && !ev.bat_attach
    |=> multifunction_control == $past(ctrl_written))
    else $error("control write not stored masked");

  AST_ATTACH_CLEARS_CTRL: assert property (
    @(posedge sys_clk) disable iff (rst)
    ev.bat_attach
    |=> multifunction_control == `CTRL_RESET)
    else $error("battery attach did not clear control");

  AST_CLOCK_ALARM_FLAG_NEEDS_ENABLE: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(clk_flag)
    |-> $past(clock_alarm_enable))
    else $error("clock alarm flag set while disabled");

  AST_OSC_FOLLOWS: assert property (
    @(posedge sys_clk) disable iff (rst)
    oscillator_run == osc_on)
    else $error("oscillator output mismatch");

  AST_WDA_NEEDS_ENABLE: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(wd_flag)
    |-> $past(watchdog_enable))
    else $error("watchdog flag set while disabled");

  AST_KICK_RESTART: assert property (
    @(posedge sys_clk) disable iff (rst)
    ev.kick
    |=> watchdog_restart)
    else $error("kick did not restart watchdog");

  AST_ENABLE_RESTART: assert property (
    @(posedge sys_clk) disable iff (rst)
    wde_rise || ev.vcc_up
    |=> watchdog_restart)
    else $error("enable rise or power-up did not restart watchdog");

  AST_WD_ROUTE: assert property (
    @(posedge sys_clk) disable iff (rst)
    !watchdog_output_n
    |-> wd_flag && !watchdog_pin_select)
    else $error("watchdog output misrouted");

  AST_WDO_DRIVEN: assert property (
    @(posedge sys_clk) disable iff (rst)
    wd_flag && !watchdog_pin_select
    |-> !watchdog_output_n)
    else $error("watchdog output not driven");

  AST_TRIP_FOLLOWS: assert property (
    @(posedge sys_clk) disable iff (rst)
    battery_trip_select ==
    multifunction_control[`CB_TRIP_HI:`CB_TRIP_LO])
    else $error("trip select output mismatch");

  AST_TEST_NEEDS_OSC: assert property (
    @(posedge sys_clk) disable iff (rst)
    battery_test_start
    |-> $past(osc_on))
    else $error("battery test with oscillator halted");

  AST_PENDING_TEST: assert property (
    @(posedge sys_clk) disable iff (rst)
    test_pending && osc_on && battery_monitor_enable
    |=> battery_test_start)
    else $error("pending battery test not started");

  AST_WRITE_CLEARS: assert property (
    @(posedge sys_clk) disable iff (rst)
    stat_sel && !set_rst && !set_wda && !set_clock_alarm_flag && !set_bor && !set_low_battery_flag
    |=> (alarm_status_flags & `STAT_CLEAR_MASK) == `STAT_RESET)
    else $error("status write did not clear flags");

  AST_STAT_TOP_ZERO: assert property (
    @(posedge sys_clk) disable iff (rst)
    alarm_status_flags[`REG_TOP_BIT] == 1'b0)
    else $error("status bit 7 set");

  AST_RESET_PULSE_SETS: assert property (
    @(posedge sys_clk) disable iff (rst)
    ev.reset_pulse
    |=> alarm_status_flags[`SB_RESET_PULSE])
    else $error("reset pulse flag not set");

  AST_WDA_SETS: assert property (
    @(posedge sys_clk) disable iff (rst)
    watchdog_enable && ev.wd_expire
    |=> wd_flag)
    else $error("watchdog flag not set on expiry");

  AST_CLOCK_ALARM_FLAG_SETS: assert property (
    @(posedge sys_clk) disable iff (rst)
    clock_alarm_enable && osc_on && ev.alarm_match
    |=> clk_flag)
    else $error("clock alarm flag not set on match");

  AST_BOR_SETS: assert property (
    @(posedge sys_clk) disable iff (rst)
    ev.bat_attach
    |=> alarm_status_flags[`SB_BAT_ATTACH])
    else $error("battery attach flag not set");

  AST_POR_SETS: assert property (
    @(posedge sys_clk) disable iff (rst)
    ev.vcc_up && !ev.bat_attach
    |=> alarm_status_flags[`SB_POWER_ON] && clk_flag == 1'b0)
    else $error("power-up flags not set");

  AST_WP_TRACKS: assert property (
    @(posedge sys_clk) disable iff (rst)
    alarm_status_flags[`SB_WP_LEVEL] == $past(ev.wp_level))
    else $error("write-protect level not tracked");

  AST_LOW_BATTERY_FLAG_SETS: assert property (
    @(posedge sys_clk) disable iff (rst)
    battery_monitor_enable && ev.bat_low && battery_test_start
    |=> bat_flag)
    else $error("low battery flag not set by test");

  AST_BAT_ALARM_OUT: assert property (
    @(posedge sys_clk) disable iff (rst)
    bat_flag
    |-> !alarm_output_n)
    else $error("low battery without alarm output");

  AST_LOW_BATTERY_FLAG_STICKY: assert property (
    @(posedge sys_clk) disable iff (rst)
    bat_flag && !stat_sel && !ev.bat_attach
    |=> bat_flag)
    else $error("low battery flag dropped");

  AST_ATTACH_CLEARS_LOW_BATTERY_FLAG: assert property (
    @(posedge sys_clk) disable iff (rst)
    ev.bat_attach && !set_low_battery_flag
    |=> !bat_flag)
    else $error("battery attach did not clear low battery flag");

  AST_ALARM_OUT_SET: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_flag || (wd_flag && watchdog_pin_select)
    |-> !alarm_output_n)
    else $error("alarm output not driven");

  AST_ALARM_OUT_IDLE: assert property (
    @(posedge sys_clk) disable iff (rst)
    !bat_flag && !clk_flag && !(wd_flag && watchdog_pin_select)
    |-> alarm_output_n)
    else $error("alarm output driven without a flag");
endmodule

/* hw/alarm_regs_cfg.svh */
// Register map, field positions and reset values of the alarm/status block
// Behaviour
// - Control bit 7 always reads zero; writing one there is ignored.
// - Battery attach clears the whole control register to zero.
// - Control bit 0 enables the clock alarm; default off.
// - Control bit 1 runs the timekeeping oscillator; default halted.
// - Control bit 2 enables the watchdog and its alarm; default off.
// - Watchdog restarts on enable rising, supply power-up, or kick pulse.
// - Control bit 3 routes watchdog alarm: 0 own output, 1 shared.
// - Control bits 5:4 select the battery trip voltage for tests.
// - Battery test on enable rise, power-up, hourly, only oscillator running.
// - Status is readable; a write clears all flags but bit 5 and any set that cycle; bit 7 zero.
// - Status bit 0 sets on reset pulse; 1 at power-up, 0 attach.
// - Status bit 1 sets when enabled watchdog expires; 0 after power events.
// - Status bit 2 sets on enabled clock alarm match while oscillator runs; 0 after power events.
// - Status bit 3 sets on battery attach; power-up leaves it unchanged.
// - Status bit 4 sets on supply power-up; 0 after battery attach.
// - Status bit 5 shows write-protect pin level; attach leaves it alone.
// - Status bit 6 sets when enabled battery test finds battery low.
// - Low-battery flag drives the shared active-low alarm output.
// - Low-battery flag stays set until status write or battery attach.
`ifndef ALARM_REGS_CFG_SVH
`define ALARM_REGS_CFG_SVH
`define ADDR_CONTROL      9'h134
`define ADDR_STATUS       9'h135
`define CTRL_RESET        8'h00
`define CTRL_WMASK        8'h7F
`define STAT_RESET        8'h00
`define STAT_CLEAR_MASK   8'h5F
`define REG_TOP_BIT       7
`define CB_CLK_ALARM_EN   0
`define CB_OSC_RUN        1
`define CB_WD_EN          2
`define CB_WD_PIN_SEL     3
`define CB_TRIP_LO        4
`define CB_TRIP_HI        5
`define CB_BAT_MON_EN     6
`define SB_RESET_PULSE    0
`define SB_WD_ALARM       1
`define SB_CLK_ALARM      2
`define SB_BAT_ATTACH     3
`define SB_POWER_ON       4
`define SB_WP_LEVEL       5
`define SB_LOW_BAT        6
`endif

/* hw/alarm_regs_pkg.sv */
// Shared types of the alarm/status register block
package alarm_regs_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [8:0] reg_addr_t;
  typedef logic [1:0] trip_sel_t;
endpackage

/* hw/event_sync.sv */
// Two-stage synchronisers and rising-edge detectors for pin-level events
module event_sync (
  input  wire logic   sys_clk,
  input  wire logic   rst,
  input  wire logic   vcc_good,
  input  wire logic   bat_good,
  input  wire logic   reset_output_sense_n,
  input  wire logic   wd_timeout,
  input  wire logic   alarm_equal,
  input  wire logic   hour_mark,
  input  wire logic   bat_below_trip,
  input  wire logic   watchdog_kick_input,
  input  wire logic   write_protect_input_n,
  event_sync_if.src   ev
);
  localparam int N = 9;
  logic [N-1:0] raw;
  logic [N-1:0] meta;
  logic [N-1:0] sync;
  logic [N-1:0] prev;
  logic [N-1:0] rise;

  // Reset sense is inverted so a low pulse shows as a rising event
  assign raw = {write_protect_input_n, watchdog_kick_input, bat_below_trip,
                hour_mark, alarm_equal, wd_timeout, ~reset_output_sense_n,
                bat_good, vcc_good};

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_sync
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          meta[i] <= 1'b0;
          sync[i] <= 1'b0;
          prev[i] <= 1'b0;
        end else begin
          meta[i] <= raw[i];
          sync[i] <= meta[i];
          prev[i] <= sync[i];
        end
      end
      assign rise[i] = sync[i] & ~prev[i];
    end
  endgenerate

  assign ev.vcc_up      = rise[0];
  assign ev.bat_attach  = rise[1];
  assign ev.reset_pulse = rise[2];
  assign ev.wd_expire   = rise[3];
  assign ev.alarm_match = rise[4];
  assign ev.hour_tick   = rise[5];
  assign ev.bat_low     = sync[6];
  assign ev.kick        = rise[7];
  assign ev.wp_level    = sync[8];
endmodule

/* hw/event_sync_if.sv */
// Synchronised event lines passed from the input stage to the register bank
interface event_sync_if;
  logic vcc_up;
  logic bat_attach;
  logic reset_pulse;
  logic wd_expire;
  logic alarm_match;
  logic hour_tick;
  logic bat_low;
  logic kick;
  logic wp_level;
  modport src (output vcc_up, bat_attach, reset_pulse, wd_expire,
               alarm_match, hour_tick, bat_low, kick, wp_level);
  modport dst (input vcc_up, bat_attach, reset_pulse, wd_expire,
               alarm_match, hour_tick, bat_low, kick, wp_level);
endinterface

/* sim/alarm_control_status_regs_tb.sv */
// Self-checking bench for the alarm control and status register pair
module alarm_control_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import alarm_regs_pkg::*;

  logic      sys_clk, rst, reg_wr;
  reg_addr_t reg_addr;
  reg_byte_t reg_wdata, reg_rdata;
  logic      vcc_good, bat_good, reset_output_sense_n, wd_timeout;
  logic      alarm_equal, hour_mark, bat_below_trip;
  logic      watchdog_kick_input, write_protect_input_n;
  logic      alarm_output_n, watchdog_output_n;
  logic      watchdog_restart, battery_test_start, oscillator_run;
  trip_sel_t battery_trip_select;
  int        n_errors, check_count, n_wd, n_bt, wd0, bt0;

  alarm_control_status_regs dut_u (.sys_clk(sys_clk), .rst(rst),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .vcc_good(vcc_good), .bat_good(bat_good),
    .reset_output_sense_n(reset_output_sense_n), .wd_timeout(wd_timeout),
    .alarm_equal(alarm_equal), .hour_mark(hour_mark),
    .bat_below_trip(bat_below_trip),
    .watchdog_kick_input(watchdog_kick_input),
    .write_protect_input_n(write_protect_input_n),
    .alarm_output_n(alarm_output_n), .watchdog_output_n(watchdog_output_n),
    .watchdog_restart(watchdog_restart),
    .battery_test_start(battery_test_start),
    .battery_trip_select(battery_trip_select),
    .oscillator_run(oscillator_run));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Pulses are one cycle wide, so counting them beats polling per scenario
  always @(posedge sys_clk) begin
    if (watchdog_restart === 1'b1) n_wd <= n_wd + 1;
    if (battery_test_start === 1'b1) n_bt <= n_bt + 1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input reg_addr_t a, input reg_byte_t e, input string m);
    @(negedge sys_clk);
    reg_addr = a;
    repeat (2) @(negedge sys_clk);
    chk(reg_rdata, e, m);
  endtask

  // Pin edges take two cycles through the synchronisers plus one to land
  task automatic settle();
    repeat (7) @(negedge sys_clk);
  endtask

  task automatic s_attach();
    wr(9'h134, 8'h35);
    rd(9'h134, 8'h35, "control write");
    bat_good = 1'b1;
    settle();
    rd(9'h134, 8'h00, "attach clears control");
    rd(9'h135, 8'h28, "attach status");
  endtask

  task automatic s_power();
    wd0 = n_wd;
    vcc_good = 1'b1;
    settle();
    rd(9'h135, 8'h38 | 8'h01, "power-up status");
    chk(8'(n_wd - wd0), 8'h01, "restart on power-up");
  endtask

  task automatic s_battery();
    int i;
    bt0 = n_bt;
    bat_below_trip = 1'b1;
    wr(9'h134, 8'hC0);
    settle();
    rd(9'h134, 8'h40, "bit 7 masked");
    chk(8'(n_bt - bt0), 8'h00, "no test with oscillator halted");
    wr(9'h134, 8'hFA);
    settle();
    chk({7'h00, oscillator_run}, 8'h01, "oscillator runs");
    chk(8'(n_bt - bt0), 8'h01, "test once oscillator runs");
    rd(9'h135, 8'h79, "low battery set");
    chk({7'h00, alarm_output_n}, 8'h00, "alarm on low battery");
    for (i = 0; i < 4; i++) begin
      wr(9'h134, 8'h42 | 8'(i << 4));
      @(negedge sys_clk);
      chk({6'h00, battery_trip_select}, 8'(i), "trip select");
    end
    bat_below_trip = 1'b0;
    hour_mark = 1'b1;
    settle();
    hour_mark = 1'b0;
    chk(8'(n_bt - bt0), 8'h02, "hourly test");
    rd(9'h135, 8'h79, "low battery sticky");
    wr(9'h135, 8'hA5);
    rd(9'h135, 8'h20, "write clears status");
    chk({7'h00, alarm_output_n}, 8'h01, "alarm released");
  endtask

  task automatic s_clock();
    alarm_equal = 1'b1;
    settle();
    alarm_equal = 1'b0;
    rd(9'h135, 8'h20, "no alarm while disabled");
    wr(9'h134, 8'h43);
    alarm_equal = 1'b1;
    settle();
    rd(9'h135, 8'h24, "clock alarm flag");
    chk({7'h00, alarm_output_n}, 8'h00, "alarm on clock flag");
    alarm_equal = 1'b0;
    wr(9'h135, 8'h00);
  endtask

  task automatic s_watchdog();
    wd0 = n_wd;
    wr(9'h134, 8'h46);
    settle();
    chk(8'(n_wd - wd0), 8'h01, "restart on enable rise");
    wd_timeout = 1'b1;
    settle();
    rd(9'h135, 8'h22, "watchdog flag");
    chk({6'h00, watchdog_output_n, alarm_output_n}, 8'h01, "own");
    wd_timeout = 1'b0;
    wr(9'h135, 8'h00);
    wr(9'h134, 8'h4E);
    wd_timeout = 1'b1;
    settle();
    chk({6'h00, watchdog_output_n, alarm_output_n}, 8'h02, "alm");
    wd_timeout = 1'b0;
    wr(9'h135, 8'h00);
    watchdog_kick_input = 1'b1;
    settle();
    watchdog_kick_input = 1'b0;
    chk(8'(n_wd - wd0), 8'h02, "restart on kick");
    wr(9'h134, 8'h4A);
    settle();
    chk(8'(n_wd - wd0), 8'h02, "no restart without enable rise");
  endtask

  task automatic s_misc();
    reset_output_sense_n = 1'b0;
    settle();
    reset_output_sense_n = 1'b1;
    rd(9'h135, 8'h21, "reset pulse flag");
    wr(9'h136, 8'hFF);
    rd(9'h136, 8'h00, "unmapped reads zero");
    rd(9'h134, 8'h4A, "unmapped write ignored");
    write_protect_input_n = 1'b0;
    settle();
    rd(9'h135, 8'h01, "write-protect level");
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    {rst, reg_wr, vcc_good, bat_good, wd_timeout, alarm_equal} = 6'h20;
    {hour_mark, bat_below_trip, watchdog_kick_input} = 3'h0;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    reset_output_sense_n = 1'b1;
    write_protect_input_n = 1'b1;
    {n_errors, check_count, n_wd, n_bt} = '0;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    settle();
    rd(9'h134, 8'h00, "control reset");
    s_attach();
    s_power();
    s_battery();
    s_clock();
    s_watchdog();
    s_misc();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    give_verdict();
  end
endmodule
